// ---- hw/psq_pkg.sv ----
// Constants and types shared by the program sequencer, its ALU and stack.
// Assumes a synchronous program store and a single 100 MHz clock domain.
//
// Function
// - A call still runs when the stack is full; the oldest entry is lost.
// - ALU results go to the named register and the flags are updated.
// - Add, add with carry, subtract, subtract with borrow, decimal adjust.
// - And, or, xor, complement, rotates, increment, decrement, to A or memory.
// - Program store is 2K words of 15 bits, by PC or table pointers.
// - Reset loads the program counter with 000H and fetches from there.
// - Enabled falling external pin with stack room branches to 004H.
// - Enabled first timer overflow with stack room branches to 008H.
// - Enabled second timer overflow with stack room branches to 00CH.
// - Vector 010H is reserved and given to no source.
// - Enabled serial module event with stack room branches to 014H.
// - Current-area table read uses high pointer bits 10..8, low pointer 7..0.
// - Last-page table read forces bits 10..8 high, page base 700H.
// - Table reads put the low byte in memory, the rest in the high latch.
// - High latch bits without a program word bit read as zero.
// - The high latch is read-only; only table reads load it.
// - Every table instruction takes two instruction cycles.
// - Data memory is 8-bit RAM; some special locations refuse writes.
// - Return stack has four levels, hidden from software.
// - With the stack full an enabled request waits until a return.
`default_nettype none
package psq_pkg;
   // ==========================================================
   // Widths and sizes.
   localparam int PC_W         = 11;
   localparam int PW_W         = 15;
   localparam int DW           = 8;
   localparam int TPTR_HI_W    = PC_W - DW;
   localparam int TDAT_HI_W    = PW_W - DW;
   localparam int FLAG_W       = 4;
   localparam int INT_N        = 4;
   localparam int STACK_LEVELS = 4;
   localparam int PM_WORDS     = 2048;
   // ==========================================================
   // Vectors and the last table page.
   localparam logic [10:0] VEC_RESET = 11'h000;
   localparam logic [10:0] VEC_EXT   = 11'h004;
   localparam logic [10:0] VEC_TM0   = 11'h008;
   localparam logic [10:0] VEC_TM1   = 11'h00c;
   localparam logic [10:0] VEC_RSVD  = 11'h010;
   localparam logic [10:0] VEC_SER   = 11'h014;
   localparam logic [2:0]  LAST_PAGE = 3'h7;
   // ==========================================================
   // Data memory locations.
   localparam logic [7:0] A_ACC     = 8'h05;
   localparam logic [7:0] A_PCL     = 8'h06;
   localparam logic [7:0] A_TBLP    = 8'h07;
   localparam logic [7:0] A_TDAT_HI = 8'h08;
   localparam logic [7:0] A_STATUS  = 8'h0a;
   localparam logic [7:0] A_TPTR_HI = 8'h1f;
   localparam logic [7:0] A_GP_BASE = 8'h30;
   // ==========================================================
   // Flag bits, request indices, instruction fields, BCD figures.
   localparam int F_C = 0;
   localparam int F_AC = 1;
   localparam int F_Z = 2;
   localparam int F_OV = 3;
   localparam int IRQ_EXT = 0;
   localparam int IRQ_TM0 = 1;
   localparam int IRQ_TM1 = 2;
   localparam int IRQ_SER = 3;
   localparam int OP_HI = 14;
   localparam int OP_LO = 12;
   localparam int SUB_HI = 11;
   localparam int SUB_LO = 8;
   localparam int M_HI = 7;
   localparam logic [3:0] BCD_MAX = 4'h9;
   localparam logic [3:0] BCD_FIX = 4'h6;
   localparam logic [7:0] BCD_BYTE = 8'h99;
   // ==========================================================
   // Enumerations.
   typedef enum logic [2:0] {
      MJ_MISC = 3'h0, MJ_ALU_A = 3'h1, MJ_ALU_M = 3'h2,
      MJ_JMP = 3'h3, MJ_CALL = 3'h4
   } psq_major_t;
   typedef enum logic [3:0] {
      MS_NOP = 4'h0, MS_RET = 4'h1, MS_RET_INT = 4'h2, MS_TRDC = 4'h3,
      MS_TRDL = 4'h4, MS_STA = 4'h5, MS_LDA = 4'h6, MS_LDI = 4'h7
   } psq_misc_t;
   typedef enum logic [3:0] {
      AL_ADD = 4'h0, AL_ADC = 4'h1, AL_SUB = 4'h2, AL_SBC = 4'h3,
      AL_DAA = 4'h4, AL_AND = 4'h5, AL_OR = 4'h6, AL_XOR = 4'h7,
      AL_CPL = 4'h8, AL_RR = 4'h9, AL_RL = 4'ha, AL_RRC = 4'hb,
      AL_RLC = 4'hc, AL_INC = 4'hd, AL_DEC = 4'he
   } psq_alu_t;
   typedef enum logic [1:0] {
      ST_FETCH = 2'b00, ST_EXEC = 2'b01, ST_XFETCH = 2'b11, ST_XEXEC = 2'b10
   } psq_state_t;
endpackage
`default_nettype wire

// ---- hw/psq_link_if.sv ----
// Carrier between the sequencer core, its ALU and its return stack.
// Assumes the core drives requests and the leaves answer in the same cycle.
`timescale 1ns/1ps
`default_nettype none
interface psq_link_if;
   logic [3:0]  op;
   logic [7:0]  a;
   logic [7:0]  b;
   logic [3:0]  fin;
   logic [7:0]  res;
   logic [3:0]  fout;
   logic        push;
   logic        pop;
   logic [10:0] pdata;
   logic [10:0] top;
   logic        full;
   modport core (output op, a, b, fin, push, pop, pdata,
                 input res, fout, top, full);
   modport alu  (input op, a, b, fin, output res, fout);
   modport stk  (input push, pop, pdata, output top, full);
endinterface
`default_nettype wire

// ---- hw/psq_alu.sv ----
// Eight-bit arithmetic and logic unit of the sequencer, purely combinational.
// Assumes operand a is the accumulator and b the memory operand.
`timescale 1ns/1ps
`default_nettype none
module psq_alu (
   // Operands and results.
   psq_link_if.alu lk
);
   logic [7:0] r;
   logic [7:0] bb;
   logic [7:0] dd;
   logic [8:0] sum;
   logic [4:0] hs;
   logic       cin;
   logic [3:0] f;

   // One adder serves all four add and subtract forms; subtract adds the
   // complement, so carry set means no borrow.
   always_comb begin
      f = lk.fin;
      r = lk.b;
      bb = lk.b;
      dd = 8'h00;
      cin = 1'b0;
      sum = 9'h000;
      hs = 5'h00;
      unique case (psq_pkg::psq_alu_t'(lk.op))
         psq_pkg::AL_ADD, psq_pkg::AL_ADC,
         psq_pkg::AL_SUB, psq_pkg::AL_SBC: begin
            bb = (lk.op[1]) ? ~lk.b : lk.b;
            cin = (lk.op[0]) ? lk.fin[psq_pkg::F_C] : lk.op[1];
            sum = {1'b0, lk.a} + {1'b0, bb} + {8'h00, cin};
            hs = {1'b0, lk.a[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
            r = sum[7:0];
            f[psq_pkg::F_C] = sum[8];
            f[psq_pkg::F_AC] = hs[4];
            f[psq_pkg::F_OV] = (lk.a[7] == bb[7]) && (r[7] != lk.a[7]);
         end
         psq_pkg::AL_DAA: begin
            if ((lk.a[3:0] > psq_pkg::BCD_MAX) || lk.fin[psq_pkg::F_AC]) begin
               dd[3:0] = psq_pkg::BCD_FIX;
            end
            if ((lk.a > psq_pkg::BCD_BYTE) || lk.fin[psq_pkg::F_C]) begin
               dd[7:4] = psq_pkg::BCD_FIX;
            end
            sum = {1'b0, lk.a} + {1'b0, dd};
            r = sum[7:0];
            f[psq_pkg::F_C] = lk.fin[psq_pkg::F_C] | sum[8];
         end
         psq_pkg::AL_AND: r = lk.a & lk.b;
         psq_pkg::AL_OR:  r = lk.a | lk.b;
         psq_pkg::AL_XOR: r = lk.a ^ lk.b;
         psq_pkg::AL_CPL: r = ~lk.b;
         psq_pkg::AL_RR:  r = {lk.b[0], lk.b[7:1]};
         psq_pkg::AL_RL:  r = {lk.b[6:0], lk.b[7]};
         psq_pkg::AL_RRC: begin
            r = {lk.fin[psq_pkg::F_C], lk.b[7:1]};
            f[psq_pkg::F_C] = lk.b[0];
         end
         psq_pkg::AL_RLC: begin
            r = {lk.b[6:0], lk.fin[psq_pkg::F_C]};
            f[psq_pkg::F_C] = lk.b[7];
         end
         psq_pkg::AL_INC: r = lk.b + 8'h01;
         psq_pkg::AL_DEC: r = lk.b - 8'h01;
         default: r = lk.b;
      endcase
      // Rotates leave the zero flag alone, every other function sets it.
      if (!(lk.op inside {psq_pkg::AL_RR, psq_pkg::AL_RL,
                          psq_pkg::AL_RRC, psq_pkg::AL_RLC})) begin
         f[psq_pkg::F_Z] = (r == 8'h00);
      end
      lk.res = r;
      lk.fout = f;
   end
endmodule
`default_nettype wire

// ---- hw/psq_stack.sv ----
// Return-address stack of the sequencer, held in flip-flops.
// Assumes push and pop never come in the same cycle.
`timescale 1ns/1ps
`default_nettype none
module psq_stack #(
   parameter int LEVELS = psq_pkg::STACK_LEVELS
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic rst,
   // Push, pop and top.
   psq_link_if.stk  lk
);
   localparam int PW = $clog2(LEVELS);
   localparam int CW = PW + 1;

   if (LEVELS < 2 || (1 << PW) != LEVELS) begin : g_chk
      $error("psq_stack: LEVELS must be a power of two");
   end

   typedef struct packed {
      logic [LEVELS-1:0][10:0] mem;
      logic [PW-1:0]           ptr;
      logic [CW-1:0]           cnt;
      logic                    full;
   } psq_stk_st_t;

   psq_stk_st_t q;
   psq_stk_st_t n;

   // A push when full still writes and wraps onto the oldest entry, so
   // the return beyond the fourth level gets the newest entry again.
   always_comb begin
      n = q;
      if (lk.push) begin
         n.mem[q.ptr] = lk.pdata;
         n.ptr = q.ptr + PW'(1);
         if (!q.full) begin
            n.cnt = q.cnt + CW'(1);
         end
      end else if (lk.pop) begin
         n.ptr = q.ptr - PW'(1);
         if (q.cnt != '0) begin
            n.cnt = q.cnt - CW'(1);
         end
      end
      n.full = (n.cnt == CW'(LEVELS));
   end

   // State register.
   always_ff @(posedge clk) begin
      if (rst) begin
         q <= '0;
      end else begin
         q <= n;
      end
   end

   assign lk.top = q.mem[q.ptr - PW'(1)];
   assign lk.full = q.full;
endmodule
`default_nettype wire

// ---- hw/psq_core.sv ----
// Program sequencer: fetch, execute, interrupts, table reads, data memory.
// Assumes a program store that returns the word one clock after PM_RD.
`timescale 1ns/1ps
`default_nettype none
module psq_core #(
   parameter int DM_DEPTH = 80
) (
   // Clock and reset.
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   // Program store port.
   output logic [10:0]      PM_ADDR,
   output logic             PM_RD,
   input  wire logic [14:0] PM_DATA,
   // Interrupt sources and enables.
   input  wire logic        EXT_INT_N,
   input  wire logic        TMR0_OVF,
   input  wire logic        TMR1_OVF,
   input  wire logic        SER_EVT,
   input  wire logic [3:0]  INT_ENABLE,
   // Observed state.
   output logic [7:0]       ACC_OUT,
   output logic [3:0]       FLAGS_OUT,
   output logic [6:0]       TABLE_HIGH_OUT,
   output logic             INT_ACK,
   output logic [10:0]      INT_VECTOR,
   output logic             STACK_FULL
);
   // ==========================================================
   // Parameter checks.
   if (DM_DEPTH < 1 || int'(psq_pkg::A_GP_BASE) + DM_DEPTH > 256)
   begin : g_chk
      $error("psq_core: DM_DEPTH does not fit the data space");
   end
   if ((1 << psq_pkg::PC_W) != psq_pkg::PM_WORDS) begin : g_chk_pm
      $error("psq_core: program counter width does not match store");
   end

   // ==========================================================
   // State.
   typedef struct packed {
      psq_pkg::psq_state_t           st;
      logic [10:0]                   pc;
      logic [10:0]                   pm_addr;
      logic                          pm_rd;
      logic [14:0]                   ir;
      logic [7:0]                    acc;
      logic [3:0]                    flags;
      logic [7:0]                    tblp;
      logic [2:0]                    tptr_hi;
      logic [6:0]                    tdat_hi;
      logic [DM_DEPTH-1:0][7:0]      gp;
      logic [3:0]                    pend;
      logic                          ext_prev;
      logic                          gie;
      logic [10:0]                   vec;
      logic                          ack;
   } psq_core_st_t;

   psq_core_st_t q;
   psq_core_st_t n;

   psq_link_if lk ();

   logic [3:0]  evt;
   logic [3:0]  clr;
   logic [3:0]  ready;
   logic        irq_go;
   logic [1:0]  irq_sel;
   psq_pkg::psq_major_t major;
   psq_pkg::psq_misc_t  misc;
   psq_pkg::psq_major_t ir_major;
   psq_pkg::psq_misc_t  ir_misc;
   logic [7:0]  m_addr;
   logic        is_table;

   // ==========================================================
   // Helper functions.

   // Lowest index wins, which is also the lowest vector address.
   function automatic logic [1:0] pick_irq(input logic [3:0] v);
      logic [1:0] s;
      s = 2'h3;
      for (int i = psq_pkg::INT_N - 1; i >= 0; i--) begin
         if (v[i]) begin
            s = 2'(i);
         end
      end
      return s;
   endfunction

   // Vector of each source; the reserved slot is never produced.
   function automatic logic [10:0] vector_of(input logic [1:0] s);
      logic [10:0] v;
      unique case (s)
         2'h0: v = psq_pkg::VEC_EXT;
         2'h1: v = psq_pkg::VEC_TM0;
         2'h2: v = psq_pkg::VEC_TM1;
         2'h3: v = psq_pkg::VEC_SER;
      endcase
      return v;
   endfunction

   // Offset of a general purpose location, or all ones when unmapped.
   function automatic int gp_index(input logic [7:0] a);
      int idx;
      idx = int'(a) - int'(psq_pkg::A_GP_BASE);
      if (idx < 0 || idx >= DM_DEPTH) begin
         idx = -1;
      end
      return idx;
   endfunction

   // Data memory read; unused special locations read as zero.
   function automatic logic [7:0] dm_rd(input logic [7:0] a);
      logic [7:0] d;
      int         idx;
      d = 8'h00;
      idx = gp_index(a);
      unique case (a)
         psq_pkg::A_ACC:    d = q.acc;
         psq_pkg::A_PCL:    d = q.pc[7:0];
         psq_pkg::A_TBLP:   d = q.tblp;
         psq_pkg::A_TPTR_HI: d = {5'h00, q.tptr_hi};
         psq_pkg::A_TDAT_HI: d = {1'b0, q.tdat_hi};
         psq_pkg::A_STATUS: d = {4'h0, q.flags};
         default: begin
            if (idx >= 0) begin
               d = q.gp[idx];
            end
         end
      endcase
      return d;
   endfunction

   // Data memory write into a next-state copy. The high latch and the
   // status byte refuse software writes; a write to the low program
   // counter byte jumps inside the page and costs a second cycle.
   function automatic psq_core_st_t dm_wr(input psq_core_st_t s,
                                          input logic [7:0] a,
                                          input logic [7:0] v);
      psq_core_st_t r;
      int           idx;
      r = s;
      idx = gp_index(a);
      unique case (a)
         psq_pkg::A_ACC:  r.acc = v;
         psq_pkg::A_TBLP: r.tblp = v;
         psq_pkg::A_TPTR_HI: r.tptr_hi = v[2:0];
         psq_pkg::A_PCL: begin
            r.pc[7:0] = v;
            r.st = psq_pkg::ST_XFETCH;
         end
         psq_pkg::A_TDAT_HI, psq_pkg::A_STATUS: r = s;
         default: begin
            if (idx >= 0) begin
               r.gp[idx] = v;
            end
         end
      endcase
      return r;
   endfunction

   // ==========================================================
   // Decode and links to the leaves.

   // Fields of the word now on the program port and of the held word.
   assign major =
      psq_pkg::psq_major_t'(PM_DATA[psq_pkg::OP_HI:psq_pkg::OP_LO]);
   assign misc =
      psq_pkg::psq_misc_t'(PM_DATA[psq_pkg::SUB_HI:psq_pkg::SUB_LO]);
   assign ir_major =
      psq_pkg::psq_major_t'(q.ir[psq_pkg::OP_HI:psq_pkg::OP_LO]);
   assign ir_misc =
      psq_pkg::psq_misc_t'(q.ir[psq_pkg::SUB_HI:psq_pkg::SUB_LO]);
   assign m_addr = PM_DATA[psq_pkg::M_HI:0];
   assign is_table = (ir_major == psq_pkg::MJ_MISC) &&
                     (ir_misc inside {psq_pkg::MS_TRDC, psq_pkg::MS_TRDL});

   // The ALU sees the executing word directly; its answer is used only
   // in the execute state.
   assign lk.op = PM_DATA[psq_pkg::SUB_HI:psq_pkg::SUB_LO];
   assign lk.a = q.acc;
   assign lk.fin = q.flags;

   // A process, not an assign, so that a change of the data behind an
   // unchanged address still reaches the ALU operand.
   always_comb begin
      lk.b = dm_rd(m_addr);
   end

   // Interrupt entry waits while the stack is full and resumes once a
   // return has freed a level; the request stays pending meanwhile.
   assign ready = q.pend & INT_ENABLE;
   assign irq_sel = pick_irq(ready);
   assign irq_go = (q.st == psq_pkg::ST_FETCH) && q.gie &&
                   (ready != 4'h0) && !lk.full;

   // Pushes on interrupt entry and on calls; a call is never held back.
   assign lk.push = irq_go ||
                    ((q.st == psq_pkg::ST_EXEC) &&
                     (major == psq_pkg::MJ_CALL));
   assign lk.pop = (q.st == psq_pkg::ST_EXEC) &&
                   (major == psq_pkg::MJ_MISC) &&
                   (misc inside {psq_pkg::MS_RET, psq_pkg::MS_RET_INT});
   assign lk.pdata = q.pc;

   // Events: falling edge of the external pin, pulses from the others.
   assign evt[psq_pkg::IRQ_EXT] = q.ext_prev & ~EXT_INT_N;
   assign evt[psq_pkg::IRQ_TM0] = TMR0_OVF;
   assign evt[psq_pkg::IRQ_TM1] = TMR1_OVF;
   assign evt[psq_pkg::IRQ_SER] = SER_EVT;

   // ==========================================================
   // Next-state logic.

   // Each instruction cycle is a fetch clock and an execute clock; jumps,
   // calls, returns, interrupt entry and table reads add a second cycle.
   always_comb begin
      n = q;
      clr = 4'h0;
      n.ack = 1'b0;
      n.pm_rd = 1'b0;
      n.ext_prev = EXT_INT_N;
      unique case (q.st)
         psq_pkg::ST_FETCH: begin
            if (irq_go) begin
               clr[irq_sel] = 1'b1;
               n.vec = vector_of(irq_sel);
               n.pc = vector_of(irq_sel);
               n.ack = 1'b1;
               n.gie = 1'b0;
               n.st = psq_pkg::ST_XFETCH;
            end else begin
               n.pc = q.pc + 11'h001;
               n.st = psq_pkg::ST_EXEC;
            end
         end
         psq_pkg::ST_EXEC: begin
            n.ir = PM_DATA;
            n.st = psq_pkg::ST_FETCH;
            case (major)
               psq_pkg::MJ_JMP, psq_pkg::MJ_CALL: begin
                  n.pc = PM_DATA[10:0];
                  n.st = psq_pkg::ST_XFETCH;
               end
               psq_pkg::MJ_ALU_A: begin
                  n.acc = lk.res;
                  n.flags = lk.fout;
               end
               psq_pkg::MJ_ALU_M: begin
                  n = dm_wr(n, m_addr, lk.res);
                  n.flags = lk.fout;
               end
               psq_pkg::MJ_MISC: begin
                  unique case (misc)
                     psq_pkg::MS_RET, psq_pkg::MS_RET_INT: begin
                        n.pc = lk.top;
                        n.gie = q.gie | (misc == psq_pkg::MS_RET_INT);
                        n.st = psq_pkg::ST_XFETCH;
                     end
                     psq_pkg::MS_TRDC: begin
                        n.pm_addr = {q.tptr_hi, q.tblp};
                        n.pm_rd = 1'b1;
                        n.st = psq_pkg::ST_XFETCH;
                     end
                     psq_pkg::MS_TRDL: begin
                        n.pm_addr = {psq_pkg::LAST_PAGE, q.tblp};
                        n.pm_rd = 1'b1;
                        n.st = psq_pkg::ST_XFETCH;
                     end
                     psq_pkg::MS_STA: n = dm_wr(n, m_addr, q.acc);
                     psq_pkg::MS_LDA: n.acc = dm_rd(m_addr);
                     psq_pkg::MS_LDI: n.acc = m_addr;
                     default: n.ir = PM_DATA;
                  endcase
               end
               default: n.ir = PM_DATA;
            endcase
         end
         psq_pkg::ST_XFETCH: begin
            n.st = psq_pkg::ST_XEXEC;
         end
         psq_pkg::ST_XEXEC: begin
            n.st = psq_pkg::ST_FETCH;
            if (is_table) begin
               n = dm_wr(n, q.ir[psq_pkg::M_HI:0],
                         PM_DATA[psq_pkg::M_HI:0]);
               n.tdat_hi = PM_DATA[psq_pkg::OP_HI:psq_pkg::DW];
            end
         end
      endcase
      // A fresh fetch is issued whenever the fetch state is entered.
      if (n.st == psq_pkg::ST_FETCH && q.st != psq_pkg::ST_FETCH) begin
         n.pm_addr = n.pc;
         n.pm_rd = 1'b1;
      end
      // A new event in the clearing cycle survives the clear.
      n.pend = (q.pend & ~clr) | evt;
   end

   // ==========================================================
   // State register; reset starts a fetch at the reset vector.
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         q <= '0;
         q.st <= psq_pkg::ST_FETCH;
         q.pc <= psq_pkg::VEC_RESET;
         q.pm_addr <= psq_pkg::VEC_RESET;
         q.pm_rd <= 1'b1;
         q.ext_prev <= 1'b1;
         q.gie <= 1'b1;
      end else begin
         q <= n;
      end
   end

   // ==========================================================
   // Leaves.
   psq_alu u_alu (
      .lk (lk.alu)
   );

   psq_stack #(
      .LEVELS (psq_pkg::STACK_LEVELS)
   ) u_stack (
      .clk (REF_CLK),
      .rst (RST),
      .lk  (lk.stk)
   );

   // ==========================================================
   // Outputs, all taken from flip-flops.
   assign PM_ADDR = q.pm_addr;
   assign PM_RD = q.pm_rd;
   assign ACC_OUT = q.acc;
   assign FLAGS_OUT = q.flags;
   assign TABLE_HIGH_OUT = q.tdat_hi;
   assign INT_ACK = q.ack;
   assign INT_VECTOR = q.vec;
   assign STACK_FULL = lk.full;
endmodule
`default_nettype wire

// ---- verif/psq_pmem.sv ----
// Program store model for the sequencer bench.
// Assumes the bench fills mem before reset ends.
`timescale 1ns/1ps
`default_nettype none
// ==========
module psq_pmem (
   // Program port.
   input wire logic        clk,
   input wire logic [10:0] addr,
   input wire logic        rd,
   output logic     [14:0] data
);
   logic [14:0] mem [2048];
   // Word one cycle after the strobe; it toggles later so stale reads show.
   always_ff @(posedge clk) begin
      if (rd) data <= mem[addr];
      else data <= ~data;
   end
endmodule
`default_nettype wire

// ---- verif/psq_core_chk.sv ----
// Checks on the sequencer's program port and interrupt outputs.
// Assumes binding into psq_core; it sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
// ==========
module psq_core_chk (
   // Watched ports.
   input wire logic        REF_CLK,
   input wire logic        RST,
   input wire logic [10:0] PM_ADDR,
   input wire logic        PM_RD,
   input wire logic        INT_ACK,
   input wire logic [10:0] INT_VECTOR,
   input wire logic        STACK_FULL
);
   // One clock domain, so clock and reset are shared.
   default clocking @(posedge REF_CLK); endclocking
   default disable iff (RST);
   property p_reset; disable iff (1'b0) RST |=> !PM_ADDR && PM_RD; endproperty
   a_reset: assert property (p_reset) else $error("reset fetch");
   property p_rd_gap; PM_RD |=> !PM_RD; endproperty
   a_rd_gap: assert property (p_rd_gap) else $error("read gap");
   property p_ack; INT_ACK |=> !INT_ACK; endproperty
   a_ack: assert property (p_ack) else $error("ack width");
   property p_vec; INT_ACK |-> INT_VECTOR inside {4, 8, 12, 20}; endproperty
   a_vec: assert property (p_vec)
      else $error("vector");
   property p_go; INT_ACK |-> !PM_RD ##1 !PM_RD ##1 PM_ADDR == INT_VECTOR;
   endproperty
   a_go: assert property (p_go) else $error("vector fetch");
   property p_full; INT_ACK |-> !$past(STACK_FULL); endproperty
   a_full: assert property (p_full) else $error("ack when full");
   property p_hold; !INT_ACK |-> $stable(INT_VECTOR); endproperty
   a_hold: assert property (p_hold) else $error("vector moved");
   property p_addr; !PM_RD |-> $stable(PM_ADDR); endproperty
   a_addr: assert property (p_addr) else $error("address moved");
   c_tm0: cover property (INT_ACK && INT_VECTOR == 11'h008);
   c_ser: cover property (INT_ACK && INT_VECTOR == 11'h014);
   c_loop: cover property (PM_RD && PM_ADDR == 11'h048);
endmodule
bind psq_core psq_core_chk u_psq_core_chk (.REF_CLK(REF_CLK), .RST(RST),
   .PM_ADDR(PM_ADDR), .PM_RD(PM_RD), .INT_ACK(INT_ACK),
   .INT_VECTOR(INT_VECTOR), .STACK_FULL(STACK_FULL));
`default_nettype wire

// ---- verif/program_sequencer_table_read_test.sv ----
// Bench: table reads, an add and the interrupt vectors.
// Assumes psq_core with the psq_pmem store model beside it.
`timescale 1ns/1ps
`default_nettype none
// ==========
module program_sequencer_table_read_test;
   logic        clk = 1'b0, rst = 1'b1, ext_n = 1'b1, rd, ack, full;
   logic [2:0]  evt = 3'h0;
   logic [3:0]  en = 4'hf, flags;
   logic [10:0] addr, vec;
   logic [14:0] data, w_c, w_l;
   logic [7:0]  acc;
   logic [6:0]  hi;
   integer      err_count = 0, comparisons = 0, cyc = 0, sum;
   integer      seed = 32'h2012e1fd;
   int          exp_q [$];
   int          vecs [4] = '{4, 8, 12, 20};
   logic [3:0]  masks [3] = '{4'h2, 4'h1, 4'hc};
   // Pointers to 306, current read, last page read, load, add, loop.
   logic [14:0] pw [9] = '{15'h0706, 15'h0507, 15'h0703, 15'h051f,
      15'h0330, 15'h0431, 15'h0630, 15'h1031, 15'h3048};
   psq_core u_psq_core (.REF_CLK(clk), .RST(rst), .PM_ADDR(addr),
      .PM_RD(rd), .PM_DATA(data), .EXT_INT_N(ext_n), .TMR0_OVF(evt[0]),
      .TMR1_OVF(evt[1]), .SER_EVT(evt[2]), .INT_ENABLE(en),
      .ACC_OUT(acc), .FLAGS_OUT(flags), .TABLE_HIGH_OUT(hi),
      .INT_ACK(ack), .INT_VECTOR(vec), .STACK_FULL(full));
   psq_pmem u_psq_pmem (.clk(clk), .addr(addr), .rd(rd), .data(data));
   // Inputs always move 1 ns after the rising edge.
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic cmp(string what, logic [10:0] exp, logic [10:0] got);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic do_reset;
      rst = 1'b1;
      repeat (3) tick();
      cmp("pm_addr", 11'h000, addr);
      rst = 1'b0;
   endtask
   // Pulses the chosen sources together; lower vectors are served first.
   task automatic irq(logic [3:0] m);
      int n;
      {evt, ext_n} = {m[3:1], ~m[0]};
      tick();
      {evt, ext_n} = 4'h1;
      for (int i = 0; i < 4; i++) if (m[i]) exp_q.push_back(vecs[i]);
      while (exp_q.size() > 0) begin
         for (n = 0; n < 200 && ack !== 1'b1; n++) tick();
         cmp("int_ack", 11'h001, {10'h000, ack});
         cmp("int_vector", 11'(exp_q.pop_front()),
             vec);
         tick();
      end
      $display("interrupt test %h done", m);
   endtask
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   initial begin
      forever #5 clk = ~clk;
   end
   // Cuts a hang short well beyond the fewer than a hundred cycles needed.
   always @(posedge clk) begin
      cyc++;
      if (cyc == 5000) begin
         err_count++;
         end_sim();
      end
   end
   initial begin
      int n;
      w_c = 15'($random(seed));
      w_l = 15'($random(seed));
      u_psq_pmem.mem[0] = 15'h3040;
      foreach (vecs[i]) u_psq_pmem.mem[vecs[i]] = 15'h0200;
      foreach (pw[i]) u_psq_pmem.mem[11'h040 + i] = pw[i];
      u_psq_pmem.mem[11'h306] = w_c;
      u_psq_pmem.mem[11'h706] = w_l;
      do_reset();
      for (n = 0; n < 300 && !(rd === 1'b1 && addr === 11'h048); n++) tick();
      repeat (4) tick();
      sum = w_c[7:0] + w_l[7:0];
      cmp("acc", {3'h0, sum[7:0]}, {3'h0, acc});
      cmp("carry", {10'h0, sum > 255}, {10'h0, flags[0]});
      cmp("half_carry", {10'h0, w_c[3:0] + w_l[3:0] > 15},
          {10'h0, flags[1]});
      cmp("zero", {10'h0, sum[7:0] == 0}, {10'h0, flags[2]});
      cmp("table_high", {4'h0, w_l[14:8]}, {4'h0, hi});
      $display("table read test done");
      foreach (masks[i]) irq(masks[i]);
      // A disabled source stays pending and is served once enabled.
      en = 4'hd;
      {evt, ext_n} = 4'h3;
      tick();
      {evt, ext_n} = 4'h1;
      repeat (20) tick();
      cmp("int_vector", 11'h014, vec);
      en = 4'hf;
      exp_q.push_back(8);
      irq(4'h0);
      cmp("stack_full", 11'h000, {10'h000, full});
      do_reset();
      end_sim();
   end
endmodule
`default_nettype wire
